// *** dv/dtsd_asserts.sv ***
`timescale 1ns/1ps
// Watches the register port and the start trigger of the top module.
module dtsd_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire start_trigger_q,
  input wire [11:0] destination_message_size_q
);
  // Decoded accesses, taken at the edge where pready is high.
  wire wr = psel & penable & pready & pwrite & pstrb[0];
  wire rd = psel & penable & pready & !pwrite;
  reg [6:0] sel_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the start selector, so a reserved code can be judged at the ports.
  always @(posedge pclk or negedge presetn)
    if (!presetn) sel_q <= 7'h00;
    else if (wr && paddr == 12'h00C) sel_q <= pwdata[6:0];
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_size; wr && paddr == 12'h000 |=> destination_message_size_q[11:8] == $past(pwdata[3:0]); endproperty
  a_size: assert property (p_size) else $error("size high not written");
  property p_cnth; rd && paddr == 12'h008 |-> prdata[31:4] == 28'h0000000; endproperty
  a_cnth: assert property (p_cnth) else $error("count high upper bits set");
  property p_ssel; rd && paddr == 12'h00C |-> prdata[31:7] == 25'h0000000; endproperty
  a_ssel: assert property (p_ssel) else $error("start selector bit 7 set");
  property p_asel; rd && paddr == 12'h010 |-> prdata[31:7] == 25'h0000000; endproperty
  a_asel: assert property (p_asel) else $error("abort selector bit 7 set");
  // The registered trigger output forgets the previous code one cycle after the write; the check waits four.
  property p_rsv; (sel_q == 7'h00) [*4] |-> !start_trigger_q; endproperty
  a_rsv: assert property (p_rsv) else $error("start on reserved code");
endmodule // dtsd_asserts

bind dtsd_top dtsd_asserts i_dtsd_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .start_trigger_q(start_trigger_q), .destination_message_size_q(destination_message_size_q));

// *** dv/dtsd_req_model.sv ***
`timescale 1ns/1ps
// Request lines; reserved lines are held busy so that a leak through them shows.
module dtsd_req_model (
  input logic [6:0] code,
  input logic lvl,
  output logic [127:0] trigger_request
);
  function automatic logic rsv(input int c);
    return c == 0 || c == 36 || c == 58 || (c >= 62 && c <= 69) || (c >= 76 && c <= 79) || c >= 82;
  endfunction
  // Only the chosen line follows the bench; reserved lines stay high and all others stay quiet.
  always_comb
    for (int c = 0; c < 128; c++)
      trigger_request[c] = rsv(c) || (c == code && lvl);
endmodule // dtsd_req_model

// *** dv/dtsd_tb.sv ***
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dest_byte_done = 0, lvl = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d, hs, ha;
  logic [6:0] code = 7'h00;
  logic [127:0] trigger_request;
  logic [11:0] size_q, cnt_q, v;
  logic pready, pslverr, er, st, ab;
  int errors = 0, n_compared = 0, seed = 84103;
  // Free running clock.
  initial forever #5 pclk = ~pclk;
  dtsd_req_model i_dtsd_req_model (.code(code), .lvl(lvl), .trigger_request(trigger_request));
  dtsd_top i_dtsd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_request(trigger_request), .dest_byte_done(dest_byte_done), .start_trigger_q(st),
    .abort_trigger_q(ab), .destination_message_size_q(size_q), .destination_byte_count_q(cnt_q));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One transfer; an idle cycle follows so psel is never assigned twice at one edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    if (n >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // High cycles expected in the window: level codes follow the 6-cycle request.
  function automatic logic [31:0] ex(input int c);
    if (i_dtsd_req_model.rsv(c)) return 0;
    return (c == 7 || (c >= 20 && c <= 29) || (c >= 46 && c <= 52)) ? 6 : 1;
  endfunction
  // Cuts a hang short well beyond the expected run.
  initial begin
    #300us;
    errors++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(0, 12'(4 * i), 0);
      chk(rd, 0);
    end
    repeat (4) begin
      d = $random(seed);
      apb(1, 12'h000, d);
      apb(0, 12'h000, 0);
      chk(rd, d[3:0]);
      chk(size_q[11:8], d[3:0]);
      apb(1, 12'h00C, d);
      apb(0, 12'h00C, 0);
      chk(rd, d[6:0]);
      apb(1, 12'h010, d);
      apb(0, 12'h010, 0);
      chk(rd, d[6:0]);
      v = {d[3:0], d[7:0] | 8'h08};
      apb(1, 12'h014, d | 32'h8);
      apb(1, 12'h018, 1);
      apb(1, 12'h004, ~d);
      apb(1, 12'h008, ~d);
      apb(0, 12'h004, 0);
      chk(rd, v[7:0]);
      apb(0, 12'h008, 0);
      chk(rd, v[11:8]);
      dest_byte_done <= 1'b1;
      repeat (3) @(posedge pclk);
      dest_byte_done <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(cnt_q, v - 12'h003);
    end
    apb(0, 12'h020, 0);
    chk(er, 1);
    for (int c = 0; c < 128; c++) begin
      apb(1, 12'h00C, c);
      apb(1, 12'h010, c);
      code <= 7'(c);
      hs = 0;
      ha = 0;
      // Drive the request on the rising edge, look at the outputs half a cycle later once settled.
      for (int i = 0; i < 14; i++) begin
        @(posedge pclk);
        lvl <= i < 6;
        @(negedge pclk);
        hs += st;
        ha += ab;
      end
      chk(hs, ex(c));
      chk(ha, ex(c));
    end
    summarize;
  end
endmodule // testbench

// *** logic/dtsd_code_class.v ***
`timescale 1ns/1ps
`include "dtsd_defines.vh"

// Classifies one selector code as reserved or level-sensitive.
module dtsd_code_class (
  input wire [6:0] code,
  output wire reserved,
  output wire level
);

  // Reserved codes connect to nothing; a 7-bit code can never exceed the top.
  assign reserved = (code == `DTSD_CODE_RESERVED0) ||
                    (code >= `DTSD_CODE_FIRST_RSVD_TOP) ||
                    (code == `DTSD_CODE_RSVD_A) ||
                    (code == `DTSD_CODE_RSVD_B) ||
                    ((code >= `DTSD_CODE_RSVD_C_LO) && (code <= `DTSD_CODE_RSVD_C_HI)) ||
                    ((code >= `DTSD_CODE_RSVD_D_LO) && (code <= `DTSD_CODE_RSVD_D_HI));

  // Only the pin-change and serial request ranges follow the level.
  assign level = (code == `DTSD_CODE_PIN_CHANGE) ||
                 ((code >= `DTSD_CODE_LVL1_LO) && (code <= `DTSD_CODE_LVL1_HI)) ||
                 ((code >= `DTSD_CODE_LVL2_LO) && (code <= `DTSD_CODE_LVL2_HI));

endmodule // dtsd_code_class

// *** logic/dtsd_defines.vh ***
`ifndef DTSD_DEFINES_VH
`define DTSD_DEFINES_VH

// Register byte offsets on the APB window.
`define DTSD_OFF_DEST_SIZE_HIGH 12'h000
`define DTSD_OFF_DEST_COUNT_LOW 12'h004
`define DTSD_OFF_DEST_COUNT_HIGH 12'h008
`define DTSD_OFF_START_TRIG_SEL 12'h00C
`define DTSD_OFF_ABORT_TRIG_SEL 12'h010
`define DTSD_OFF_DEST_SIZE_LOW 12'h014
`define DTSD_OFF_COUNT_CTRL 12'h018

// Field positions.
`define DTSD_NIB_MSB 3
`define DTSD_SEL_MSB 6
`define DTSD_CTRL_LOAD_BIT 0
`define DTSD_CTRL_DEC_BIT 1

// Reset values.
`define DTSD_RST_NIBBLE 4'h0
`define DTSD_RST_BYTE 8'h00
`define DTSD_RST_SEL 7'h00
`define DTSD_RST_COUNT 12'h000

// Trigger code table limits.
`define DTSD_CODE_RESERVED0 7'h00
`define DTSD_CODE_FIRST_RSVD_TOP 7'h52
`define DTSD_CODE_LAST 7'h7F
`define DTSD_CODE_PIN_CHANGE 7'h07
`define DTSD_CODE_LVL1_LO 7'h14
`define DTSD_CODE_LVL1_HI 7'h1D
`define DTSD_CODE_LVL2_LO 7'h2E
`define DTSD_CODE_LVL2_HI 7'h34
`define DTSD_CODE_CH1_EV_LO 7'h10
`define DTSD_CODE_CH1_EV_HI 7'h13
`define DTSD_CODE_CH2_EV_LO 7'h2A
`define DTSD_CODE_CH2_EV_HI 7'h2D
`define DTSD_CODE_RSVD_A 7'h24
`define DTSD_CODE_RSVD_B 7'h3A
`define DTSD_CODE_RSVD_C_LO 7'h3E
`define DTSD_CODE_RSVD_C_HI 7'h45
`define DTSD_CODE_RSVD_D_LO 7'h4C
`define DTSD_CODE_RSVD_D_HI 7'h4F

// Width of the request line vector.
`define DTSD_NREQ 128

`endif

// *** logic/dtsd_top.v ***
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dtsd_defines.vh"

module dtsd_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [127:0] trigger_request,
  input wire dest_byte_done,
  output reg start_trigger_q,
  output reg abort_trigger_q,
  output reg [11:0] destination_message_size_q,
  output reg [11:0] destination_byte_count_q
);

  reg [127:0] req_meta_q;
  reg [127:0] req_sync_q;
  reg done_meta_q;
  reg done_sync_q;
  reg [6:0] start_trigger_code_q;
  reg [6:0] abort_trigger_code_q;
  reg [31:0] rdata_d;
  reg map_hit;
  wire start_trig;
  wire abort_trig;
  wire wr_take;
  wire rd_take;

  // Byte-lane 0 carries all of these registers of up to 8 bits.
  function wr_lane0;
    input [3:0] strb;
    begin
      wr_lane0 = strb[0];
    end
  endfunction

  // Two-flop synchronisers for request lines and the count strobe from outside.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_meta_q <= {`DTSD_NREQ{1'b0}};
      req_sync_q <= {`DTSD_NREQ{1'b0}};
      done_meta_q <= 1'b0;
      done_sync_q <= 1'b0;
    end else begin
      req_meta_q <= trigger_request;
      req_sync_q <= req_meta_q;
      done_meta_q <= dest_byte_done;
      done_sync_q <= done_meta_q;
    end
  end

  // Zero-wait slave: access phase completes in its first cycle.
  assign wr_take = psel & penable & pwrite;
  assign rd_take = psel & penable & ~pwrite;

  // Address decode for reads; an unmapped address answers with an error.
  always @* begin
    rdata_d = 32'h00000000;
    map_hit = 1'b1;
    if (paddr == `DTSD_OFF_DEST_SIZE_HIGH) begin
      rdata_d[`DTSD_NIB_MSB:0] = destination_message_size_q[11:8];
    end else if (paddr == `DTSD_OFF_DEST_COUNT_LOW) begin
      rdata_d[7:0] = destination_byte_count_q[7:0];
    end else if (paddr == `DTSD_OFF_DEST_COUNT_HIGH) begin
      rdata_d[`DTSD_NIB_MSB:0] = destination_byte_count_q[11:8];
    end else if (paddr == `DTSD_OFF_START_TRIG_SEL) begin
      rdata_d[`DTSD_SEL_MSB:0] = start_trigger_code_q;
    end else if (paddr == `DTSD_OFF_ABORT_TRIG_SEL) begin
      rdata_d[`DTSD_SEL_MSB:0] = abort_trigger_code_q;
    end else if (paddr == `DTSD_OFF_DEST_SIZE_LOW) begin
      rdata_d[7:0] = destination_message_size_q[7:0];
    end else if (paddr == `DTSD_OFF_COUNT_CTRL) begin
      rdata_d = 32'h00000000;
    end else begin
      map_hit = 1'b0;
    end
  end

  // Bus answer registers: pready and pslverr are pulses of the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // Writable configuration registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      destination_message_size_q <= {`DTSD_RST_NIBBLE, `DTSD_RST_BYTE};
      start_trigger_code_q <= `DTSD_RST_SEL;
      abort_trigger_code_q <= `DTSD_RST_SEL;
    end else if (wr_take & pready & wr_lane0(pstrb)) begin
      if (paddr == `DTSD_OFF_DEST_SIZE_HIGH) begin
        destination_message_size_q[11:8] <= pwdata[`DTSD_NIB_MSB:0];
      end else if (paddr == `DTSD_OFF_DEST_SIZE_LOW) begin
        destination_message_size_q[7:0] <= pwdata[7:0];
      end else if (paddr == `DTSD_OFF_START_TRIG_SEL) begin
        start_trigger_code_q <= pwdata[`DTSD_SEL_MSB:0];
      end else if (paddr == `DTSD_OFF_ABORT_TRIG_SEL) begin
        abort_trigger_code_q <= pwdata[`DTSD_SEL_MSB:0];
      end
    end
  end

  // Running destination count: software cannot write it, only reload or step it.
  // Load is taken from the control register; decrement comes from the engine strobe.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      destination_byte_count_q <= `DTSD_RST_COUNT;
    end else if (wr_take & pready & wr_lane0(pstrb) & (paddr == `DTSD_OFF_COUNT_CTRL) &
                 pwdata[`DTSD_CTRL_LOAD_BIT]) begin
      destination_byte_count_q <= destination_message_size_q;
    end else if (done_sync_q && (destination_byte_count_q != `DTSD_RST_COUNT)) begin
      destination_byte_count_q <= destination_byte_count_q - 12'h001;
    end
  end

  dtsd_trig_sel u_start (
    .pclk(pclk),
    .presetn(presetn),
    .code(start_trigger_code_q),
    .req_sync(req_sync_q),
    .trig(start_trig)
  );

  dtsd_trig_sel u_abort (
    .pclk(pclk),
    .presetn(presetn),
    .code(abort_trigger_code_q),
    .req_sync(req_sync_q),
    .trig(abort_trig)
  );

  // Registered trigger outputs toward the transfer engine.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_trigger_q <= 1'b0;
      abort_trigger_q <= 1'b0;
    end else begin
      start_trigger_q <= start_trig;
      abort_trigger_q <= abort_trig;
    end
  end

endmodule // dtsd_top

// *** logic/dtsd_trig_sel.v ***
`timescale 1ns/1ps
`include "dtsd_defines.vh"

// Selects one synchronised request line and turns it into a trigger pulse or level.
module dtsd_trig_sel (
  input wire pclk,
  input wire presetn,
  input wire [6:0] code,
  input wire [127:0] req_sync,
  output reg trig
);

  wire reserved;
  wire level;
  wire line;
  reg line_q;

  dtsd_code_class u_class (
    .code(code),
    .reserved(reserved),
    .level(level)
  );

  // A reserved code reads as a permanently quiet line.
  assign line = reserved ? 1'b0 : req_sync[code];

  // Previous sample for rising edge detection.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 1'b0;
    end else begin
      line_q <= line;
    end
  end

  // Level sources pass while high; all others fire once per rising edge.
  always @* begin
    if (level) begin
      trig = line;
    end else begin
      trig = line & ~line_q;
    end
  end

endmodule // dtsd_trig_sel
